/* rtl/brmr_pkg.sv */
/*
  Package for the burner remote register bank: register addresses, field
  positions, codes and timing figures shared by the design.
  Assumes a 100 MHz ref_clk and a word-addressed register port.
*/
`default_nettype none
package brmr_pkg;
  localparam logic [15:0] ADDR_VP_MODE = 16'h0067;
  localparam logic [15:0] ADDR_VP_OPTION = 16'h0068;
  localparam logic [15:0] ADDR_VP_SECONDS = 16'h0069;
  localparam logic [15:0] ADDR_CMD_STATUS = 16'h0054;
  localparam logic [15:0] ADDR_REMOTE_CMD = 16'h007F;
  localparam logic [15:0] ADDR_DATA_READY = 16'h01BA;
  localparam logic [15:0] ADDR_COMPAT = 16'h01BB;
  // command bit positions
  localparam int BIT_AUTO = 0;
  localparam int BIT_OFF = 1;
  localparam int BIT_HIGH = 2;
  localparam int BIT_LOW = 3;
  localparam int BIT_RESET = 4;
  localparam int BIT_MIRROR = 15;
  localparam logic [15:0] CMD_ACTIVE_MASK = 16'h001F;
  localparam logic [15:0] CMD_ZERO_MASK = 16'h00E0;
  localparam logic [15:0] READY_MASK = 16'h0009;
  localparam logic [15:0] COMPAT_MASK = 16'h0109;
  // valve proving codes
  localparam logic [2:0] VP_MODE_MAX = 3'h4;
  localparam logic [1:0] VP_OPT_UNCOMM = 2'h1;
  localparam logic [1:0] VP_OPT_COMM = 2'h2;
  // identify reply layout
  localparam int ID_FRAME_BYTES = 26;
  localparam int ID_DESC_FIRST = 5;
  localparam int ID_DESC_BYTES = 11;
  localparam int ID_NA_FIRST = 16;
  localparam int ID_CRC_FIRST = 24;
  localparam logic [7:0] ID_FUNC = 8'h11;
  localparam logic [7:0] ID_COUNT = 8'h15;
  localparam logic [7:0] ID_RUN_ON = 8'hFF;
  localparam logic [7:0] ID_NA_FILL = 8'h00;
  // timing
  localparam longint CLK_HZ = 100000000;
  localparam longint REFRESH_MAX_S = 120;
  localparam longint REFRESH_MAX_CYC = REFRESH_MAX_S * CLK_HZ;
  typedef struct packed {
    logic [2:0] vp_mode;
    logic [1:0] vp_option;
    logic [15:0] vp_seconds;
  } brmr_valve_t;
  typedef struct packed {
    logic auto_mode;
    logic cmd_off;
    logic cmd_high;
    logic cmd_low;
    logic reset_pending;
  } brmr_cmd_t;
endpackage
`default_nettype wire

/* rtl/brmr_regs.sv */
/*
  Burner remote register bank: valve proving readback, remote command with
  status mirror and refresh watchdog, data ready and compatibility maps,
  and the byte source for the identify (function 17) reply.
  Assumes a framing engine in front that issues one-cycle register strokes
  and pulls reply bytes by index; the CRC bytes are filled by that engine.
*/
`default_nettype none
// What this block does
// - valve proving mode, option, seconds read-only
// - bit0 autonomous, bit1 off, bit4 reset
// - high/low fire demands only in run
// - bits 5-7 zero, bits 8-14 ignored
// - bit 15 copied to command status
// - data ready bits 0 and 3 only
// - compatibility bits 0 and 3, 4-7 unused
// - compatibility bit 8 legacy series, 9-15 reserved
// - identify reply is 26 bytes framed
// - byte 3 fixed slave identifier
// - byte 4 run indicator always FF
// - bytes 5-15 model description text
// - status shows active state and mirror
module brmr_regs
  import brmr_pkg::*;
#(
  parameter longint REFRESH_CYCLES = REFRESH_MAX_CYC,
  parameter logic [7:0] SLAVE_ID = 8'h5A // arbitrary neutral value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_strobe,
  input wire logic reg_write,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_error,
  input wire brmr_pkg::brmr_valve_t valve_in,
  input wire logic in_run,
  input wire logic relay_ready,
  input wire logic alt_ready,
  input wire logic relay_compat,
  input wire logic alt_compat,
  input wire logic legacy_compat,
  input wire logic [ID_DESC_BYTES*8-1:0] model_order_string,
  input wire logic [7:0] id_slave_addr,
  input wire logic [4:0] id_index,
  output logic [7:0] id_byte,
  output brmr_pkg::brmr_cmd_t burner_controller_cmd,
  output logic remote_reset_pulse
);
  brmr_cmd_t cmd_reg;
  logic mirror_reg;
  logic [39:0] wd_reg;
  logic reset_pulse_reg;
  logic [15:0] rdata_reg;
  logic ack_reg;
  logic err_reg;
  logic [7:0] id_reg;
  logic [15:0] status_word;
  logic cmd_wr;
  logic cmd_valid;
  logic [7:0] low_bits;
  logic refresh;
  logic wd_expired;

  // command write acceptance: one low bit, zero bits 5-7
  assign cmd_wr = reg_strobe && reg_write && (reg_addr == ADDR_REMOTE_CMD);
  assign low_bits = reg_wdata[7:0];
  assign cmd_valid = ((reg_wdata & CMD_ZERO_MASK) == 16'h0000)
    && ($countones(low_bits) == 1);
  assign refresh = cmd_wr && cmd_valid
    && (reg_wdata[BIT_OFF] || reg_wdata[BIT_HIGH] || reg_wdata[BIT_LOW]);
  assign wd_expired = (wd_reg >= 40'(REFRESH_CYCLES - 1));

  // status word layout, upper bits 5-14 zero
  assign status_word = {mirror_reg, 10'h000, cmd_reg.reset_pending, cmd_reg.cmd_low,
    cmd_reg.cmd_high, cmd_reg.cmd_off, cmd_reg.auto_mode};

  // commanded state; bits 8-14 never looked at
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_reg <= '{auto_mode: 1'b1, default: 1'b0};
    end else if (cmd_wr && cmd_valid) begin
      cmd_reg.auto_mode <= reg_wdata[BIT_AUTO];
      cmd_reg.cmd_off <= reg_wdata[BIT_OFF];
      cmd_reg.cmd_high <= reg_wdata[BIT_HIGH];
      cmd_reg.cmd_low <= reg_wdata[BIT_LOW];
      cmd_reg.reset_pending <= reg_wdata[BIT_RESET];
    end else if (wd_expired && (cmd_reg.cmd_off || cmd_reg.cmd_high || cmd_reg.cmd_low)) begin
      cmd_reg <= '{auto_mode: 1'b1, default: 1'b0};
    end else if (reset_pulse_reg) begin
      cmd_reg.reset_pending <= 1'b0;
      cmd_reg.auto_mode <= 1'b1;
    end
  end

  // mirror of bit 15 on every command write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mirror_reg <= 1'b0;
    end else if (cmd_wr) begin
      mirror_reg <= reg_wdata[BIT_MIRROR];
    end
  end

  // refresh watchdog for commanded off/high/low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_reg <= '0;
    end else if (refresh || !(cmd_reg.cmd_off || cmd_reg.cmd_high || cmd_reg.cmd_low)) begin
      wd_reg <= '0;
    end else if (!wd_expired) begin
      wd_reg <= wd_reg + 40'h1;
    end
  end

  // one-cycle reset request to the burner control
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_pulse_reg <= 1'b0;
    end else begin
      reset_pulse_reg <= cmd_reg.reset_pending && !reset_pulse_reg;
    end
  end

  // fire demands gated by run state
  always_comb begin
    burner_controller_cmd = cmd_reg;
    burner_controller_cmd.cmd_high = cmd_reg.cmd_high && in_run;
    burner_controller_cmd.cmd_low = cmd_reg.cmd_low && in_run;
  end
  assign remote_reset_pulse = reset_pulse_reg;

  // register read and answer, one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= reg_strobe;
      err_reg <= 1'b0;
      rdata_reg <= '0;
      if (reg_strobe) begin
        case (reg_addr)
          ADDR_VP_MODE: rdata_reg <= {13'h0000, valve_in.vp_mode};
          ADDR_VP_OPTION: rdata_reg <= {14'h0000, valve_in.vp_option};
          ADDR_VP_SECONDS: rdata_reg <= valve_in.vp_seconds;
          ADDR_CMD_STATUS: rdata_reg <= status_word;
          ADDR_REMOTE_CMD: rdata_reg <= status_word;
          ADDR_DATA_READY: rdata_reg <= READY_MASK & {12'h000, alt_ready, 2'b00,
            relay_ready};
          ADDR_COMPAT: rdata_reg <= COMPAT_MASK & {7'h00, legacy_compat, 4'h0,
            alt_compat, 2'b00, relay_compat};
          default: err_reg <= 1'b1;
        endcase
        if (reg_write && !(cmd_wr && cmd_valid)) begin
          err_reg <= 1'b1;
        end
      end
    end
  end
  assign reg_rdata = rdata_reg;
  assign reg_ack = ack_reg;
  assign reg_error = err_reg;

  // identify reply byte source
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      id_reg <= '0;
    end else begin
      if (id_index == 5'd0) id_reg <= id_slave_addr;
      else if (id_index == 5'd1) id_reg <= ID_FUNC;
      else if (id_index == 5'd2) id_reg <= ID_COUNT;
      else if (id_index == 5'd3) id_reg <= SLAVE_ID;
      else if (id_index == 5'd4) id_reg <= ID_RUN_ON;
      else if (id_index < 5'(ID_NA_FIRST)) begin
        id_reg <= model_order_string[8*(5'(ID_DESC_BYTES) - 5'd1 -
          (id_index - 5'(ID_DESC_FIRST))) +: 8];
      end else id_reg <= ID_NA_FILL;
    end
  end
  assign id_byte = id_reg;

  // checks
  a_mirror_copy: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_wr |=> mirror_reg == $past(reg_wdata[BIT_MIRROR]))
    else $error("mirror bit not copied");
  a_status_update: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_wr && cmd_valid && reg_wdata[BIT_OFF])
    |=> cmd_reg.cmd_off && !cmd_reg.auto_mode)
    else $error("off command not taken");
  a_fire_gated: assert property (@(posedge ref_clk) disable iff (rst)
    !in_run |-> !burner_controller_cmd.cmd_high && !burner_controller_cmd.cmd_low)
    else $error("fire demand outside run");
  a_bad_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_wr && !cmd_valid) |=> $stable(cmd_reg))
    else $error("invalid command accepted");
  a_timeout_auto: assert property (@(posedge ref_clk) disable iff (rst)
    (wd_expired && !cmd_wr && cmd_reg.cmd_off) |=> cmd_reg.auto_mode)
    else $error("timeout did not revert");
  a_ready_unused: assert property (@(posedge ref_clk) disable iff (rst)
    (ack_reg && $past(reg_addr) == ADDR_DATA_READY)
    |-> rdata_reg == {12'h000, $past(alt_ready), 2'b00, $past(relay_ready)})
    else $error("ready bits misplaced");
  a_compat_map: assert property (@(posedge ref_clk) disable iff (rst)
    (ack_reg && $past(reg_addr) == ADDR_COMPAT)
    |-> rdata_reg == {7'h00, $past(legacy_compat), 4'h0, $past(alt_compat), 2'b00,
    $past(relay_compat)})
    else $error("compatibility bits misplaced");
  a_reset_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_wr && cmd_valid && reg_wdata[BIT_RESET] && !cmd_reg.reset_pending)
    |=> ##1 remote_reset_pulse)
    else $error("reset request not passed on");
  a_run_byte: assert property (@(posedge ref_clk) disable iff (rst)
    id_index == 5'd4 |=> id_byte == ID_RUN_ON)
    else $error("run byte wrong");
  a_slave_id: assert property (@(posedge ref_clk) disable iff (rst)
    id_index == 5'd3 |=> id_byte == SLAVE_ID)
    else $error("slave id wrong");
endmodule
`default_nettype wire

/* testbench/brmr_master.sv */
/*
  Register master model: one-cycle strobes, address and data held to the answer.
  Assumes the bank answers with ack one cycle after each strobe.
*/
`default_nettype none
module brmr_master (
  input wire logic ref_clk,
  output logic reg_strobe,
  output logic reg_write,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_error
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus before the first access
  initial begin
    reg_strobe = 1'b0;
    reg_write = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // callers send one low-byte bit, bits 5-7 zero, except refusal probes
  // bank flags are read before commands are sent
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [17:0] ans);
    @(posedge ref_clk) #1;
    reg_strobe = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_strobe = 1'b0;
    ans = {reg_ack, reg_error, reg_rdata};
    @(posedge ref_clk) #1;
    // released lines show no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

/* testbench/brmr_regs_test.sv */
/*
  Self-checking bench for the burner remote register bank.
  Assumes brmr_pkg, brmr_regs and the brmr_master model are compiled first.
*/
`default_nettype none
module brmr_regs_test;
  import brmr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_strobe, reg_write, reg_ack, reg_error, in_run = 1'b0, pulse;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] id_byte, exp_b;
  logic [4:0] id_index = 5'h00;
  logic [4:0] flags = 5'h1F;
  logic [7:0] own_addr = 8'h21;
  logic [87:0] mos = "MODEL-TEXT1";
  brmr_valve_t valve = '{3'h4, 2'h2, 16'h1234};
  brmr_cmd_t cmd;
  int miscompares = 0;
  int num_checks = 0;
  int pulses = 0;
  brmr_master i_brmr_master (.ref_clk(ref_clk), .reg_strobe(reg_strobe),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_error(reg_error));
  brmr_regs #(.REFRESH_CYCLES(100), .SLAVE_ID(8'h3C)) i_brmr_regs (.ref_clk(ref_clk),
    .rst(rst), .reg_strobe(reg_strobe), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_error(reg_error), .valve_in(valve), .in_run(in_run), .relay_ready(flags[0]),
    .alt_ready(flags[1]), .relay_compat(flags[2]), .alt_compat(flags[3]),
    .legacy_compat(flags[4]), .model_order_string(mos), .id_slave_addr(own_addr),
    .id_index(id_index),
    .id_byte(id_byte), .burner_controller_cmd(cmd), .remote_reset_pulse(pulse));
  // clock and reset pulse counter
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (pulse === 1'b1) pulses++;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  // one access, ack always expected, read data on reads only
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic err, input logic [15:0] rd);
    logic [17:0] ans;
    i_brmr_master.xfer(w, a, d, ans);
    chk("ack_err", {14'h0000, ans[17:16]}, {14'h0000, 1'b1, err});
    if (!w) chk("rdata", ans[15:0], rd);
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk("cmd", 16'(cmd), 16'h0010);
    acc(0, ADDR_VP_MODE, 0, 0, 16'h0004);
    acc(0, ADDR_VP_OPTION, 0, 0, 16'h0002);
    acc(0, ADDR_VP_SECONDS, 0, 0, 16'h1234);
    acc(1, ADDR_VP_MODE, 16'h0001, 1, 0);
    acc(0, 16'h0070, 0, 1, 16'h0000);
    acc(0, ADDR_DATA_READY, 0, 0, 16'h0009);
    acc(0, ADDR_COMPAT, 0, 0, 16'h0109);
    // relay family absent, alternate present, no legacy series
    flags = 5'h0A;
    acc(0, ADDR_DATA_READY, 0, 0, 16'h0008);
    acc(0, ADDR_COMPAT, 0, 0, 16'h0008);
    acc(1, ADDR_REMOTE_CMD, 16'h8002, 0, 0);
    acc(0, ADDR_CMD_STATUS, 0, 0, 16'h8002);
    acc(0, ADDR_REMOTE_CMD, 0, 0, 16'h8002);
    chk("cmd", 16'(cmd), 16'h0008);
    acc(1, ADDR_REMOTE_CMD, 16'h0006, 1, 0);
    acc(0, ADDR_CMD_STATUS, 0, 0, 16'h0002);
    acc(1, ADDR_REMOTE_CMD, 16'h0020, 1, 0);
    acc(1, ADDR_REMOTE_CMD, 16'h7F04, 0, 0);
    chk("cmd", 16'(cmd), 16'h0000);
    in_run = 1'b1;
    @(posedge ref_clk) #1 chk("cmd", 16'(cmd), 16'h0004);
    acc(0, ADDR_CMD_STATUS, 0, 0, 16'h0004);
    acc(1, ADDR_REMOTE_CMD, 16'h0008, 0, 0);
    chk("cmd", 16'(cmd), 16'h0002);
    acc(1, ADDR_REMOTE_CMD, 16'h0001, 0, 0);
    chk("cmd", 16'(cmd), 16'h0010);
    // refresh keeps off, silence returns to autonomous
    acc(1, ADDR_REMOTE_CMD, 16'h0002, 0, 0);
    repeat (60) @(posedge ref_clk);
    acc(1, ADDR_REMOTE_CMD, 16'h0002, 0, 0);
    repeat (60) @(posedge ref_clk);
    #1 chk("cmd", 16'(cmd), 16'h0008);
    repeat (60) @(posedge ref_clk);
    #1 chk("cmd", 16'(cmd), 16'h0010);
    acc(1, ADDR_REMOTE_CMD, 16'h0010, 0, 0);
    repeat (6) @(posedge ref_clk);
    #1 chk("pulses", 16'(pulses), 16'h0001);
    chk("cmd", 16'(cmd), 16'h0010);
    // identify reply bytes in order
    for (int i = 0; i < ID_FRAME_BYTES; i++) begin
      @(posedge ref_clk) #1 id_index = 5'(i);
      exp_b = (i >= 5 && i <= 15) ? mos[87-8*(i-5) -: 8] : 8'h00;
      case (i)
        0: exp_b = 8'h21;
        1: exp_b = 8'h11;
        2: exp_b = 8'h15;
        3: exp_b = 8'h3C;
        4: exp_b = 8'hFF;
        default: ;
      endcase
      @(posedge ref_clk) #1 chk("id_byte", 16'(id_byte), 16'(exp_b));
    end
    print_verdict;
  end
endmodule
`default_nettype wire
